// ==== hw/rst_seq_pkg.sv ====
// constants for reset sequencing, strap sampling and time-reference sampling
package rst_seq_pkg;
    // clock rate
    localparam int CLK_HZ            = 10_000_000;
    localparam int CLK_NS            = 100;
    // times in their own unit
    localparam int HARD_MIN_US       = 100;
    localparam int CLK_STABLE_US     = 100;
    localparam int PLL_LOCK_MAX_US   = 100;
    // cycle counts; least times round up, longest round down
    localparam int HARD_MIN_CYC      = (HARD_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int CLK_STABLE_CYC    = (CLK_STABLE_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int PLL_LOCK_CYC      = (PLL_LOCK_MAX_US * 1000) / CLK_NS;
    localparam int SOFT_MIN_CYC      = 3;
    localparam int STRAP_SETUP_CYC   = 4;
    localparam int STRAP_HOLD_CYC    = 2;
    localparam int STRAP_RELEASE_CYC = 5;
    localparam int TREF_MIN_PHASE    = 2;
    // widths and reset values
    localparam int STRAP_W           = 8;
    localparam int CNT_W             = 12;
    localparam int NUM_PLL           = 4;
    localparam int TBASE_W           = 32;
    localparam logic [7:0] STRAP_RST = 8'h00;
endpackage

// ==== hw/rst_link_if.sv ====
// board reset controller to processor reset/strap/time-reference link
`timescale 1ns/10ps
interface rst_link_if #(parameter int STRAP_W = 8);
    logic               hard_reset_in;
    logic               soft_reset_in;
    logic [STRAP_W-1:0] strap_out;
    logic               strap_oe;
    logic               tref;
    wire  [STRAP_W-1:0] strap_pin;

    // pulls settle undriven straps low
    assign strap_pin = strap_oe ? strap_out : '0;

    modport ctrl (output hard_reset_in, output soft_reset_in, output strap_out,
                  output strap_oe, output tref);
    modport dev  (input hard_reset_in, input soft_reset_in, input strap_pin, input tref);
endinterface

// ==== hw/sync2.sv ====
// two-flop synchroniser, parameterised width
`timescale 1ns/10ps
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    // first stage read only by the second
    always_comb begin
        next_meta = d;
        next_q    = meta;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= next_meta;
            q    <= next_q;
        end
    end
endmodule

// ==== hw/reset_dev.sv ====
// device end: reset sequencing, strap capture, pll lock wait, time reference
// Function
// - primary clock times all reset and sampling
// - controller holds hard reset at least 100us
// - controller holds soft reset three cycles minimum
// - clock stable 100us before hard release
// - non-pll straps valid four cycles before release
// - all straps held two cycles after release
// - strap drivers release within five cycles
// - each pll locks within 100us
// - time reference sampled by platform clock latch
// - sample drives interrupt_ctrl counters and time base
// - time reference phases at least two clocks
// - tied-low time reference stops counters advancing
`timescale 1ns/10ps
module reset_dev #(
    parameter int STRAP_W      = rst_seq_pkg::STRAP_W,
    parameter int PLL_LOCK_CYC = rst_seq_pkg::PLL_LOCK_CYC,
    parameter int TBASE_W      = rst_seq_pkg::TBASE_W
) (
    input  wire logic               clk_sys,
    input  wire logic               rst,
    rst_link_if.dev                 link,
    output logic                    core_reset,
    output logic                    soft_reset_req,
    output logic [STRAP_W-1:0]      strap_cfg,
    output logic [rst_seq_pkg::NUM_PLL-1:0] pll_locked,
    output logic                    tref_tick,
    output logic [TBASE_W-1:0]      intc_count,
    output logic [TBASE_W-1:0]      time_base
);
    localparam int NP = rst_seq_pkg::NUM_PLL;
    localparam int LW = $clog2(PLL_LOCK_CYC + 1);

    typedef enum logic [2:0] {
        ST_HARD = 3'h1,
        ST_LOCK = 3'h2,
        ST_RUN  = 3'h4
    } dev_state_t;

    logic               hard_s;
    logic               soft_s;
    logic               tref_s;
    logic [STRAP_W-1:0] strap_s;
    logic [STRAP_W+2:0] sync_in;
    logic [STRAP_W+2:0] sync_out;

    dev_state_t         state;
    dev_state_t         next_state;
    logic [STRAP_W-1:0] next_strap_cfg;
    logic [LW-1:0]      lock_cnt;
    logic [LW-1:0]      next_lock_cnt;
    logic [NP-1:0]      next_pll_locked;
    logic               tref_d;
    logic               next_tref_tick;
    logic [TBASE_W-1:0] next_intc_count;
    logic [TBASE_W-1:0] next_time_base;

    // every pin enters through two flops; the clock is the primary clock
    // hard reset enters inverted: cleared flops read as reset held, no false release
    assign sync_in = {!link.hard_reset_in, link.soft_reset_in, link.tref, link.strap_pin};
    sync2 #(.W(STRAP_W + 3)) u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d       (sync_in),
        .q       (sync_out)
    );
    assign hard_s  = !sync_out[STRAP_W+2];
    assign soft_s  = sync_out[STRAP_W+1];
    assign tref_s  = sync_out[STRAP_W];
    assign strap_s = sync_out[STRAP_W-1:0];

    // each pll model gets a staggered lock point inside the bound
    function automatic logic [LW-1:0] lock_point(input int idx);
        lock_point = LW'(PLL_LOCK_CYC - idx);
    endfunction

    // reset sequence: hard reset, pll lock wait, run
    always_comb begin
        next_state      = state;
        next_strap_cfg  = strap_cfg;
        next_lock_cnt   = lock_cnt;
        next_pll_locked = pll_locked;
        case (state)
            ST_HARD: begin
                next_lock_cnt   = '0;
                next_pll_locked = '0;
                // straps track the pins while hard reset is held
                next_strap_cfg  = strap_s;
                if (!hard_s) begin
                    next_state = ST_LOCK; // last sampled value is kept
                end
            end
            ST_LOCK: begin
                // the pll bound is a count of primary cycles
                if (lock_cnt != LW'(PLL_LOCK_CYC)) begin
                    next_lock_cnt = lock_cnt + LW'(1);
                end
                for (int i = 0; i < NP; i++) begin
                    if (lock_cnt >= lock_point(i)) begin
                        next_pll_locked[i] = 1'b1;
                    end
                end
                if (&pll_locked) begin
                    next_state = ST_RUN; // release only after all lock
                end
            end
            ST_RUN: begin
                // straps frozen for the rest of operation
            end
            default: begin
                next_state = ST_HARD;
            end
        endcase
        if (hard_s) begin
            next_state = ST_HARD;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state      <= ST_HARD;
            strap_cfg  <= rst_seq_pkg::STRAP_RST;
            lock_cnt   <= '0;
            pll_locked <= '0;
        end else begin
            state      <= next_state;
            strap_cfg  <= next_strap_cfg;
            lock_cnt   <= next_lock_cnt;
            pll_locked <= next_pll_locked;
        end
    end

    assign core_reset     = (state != ST_RUN);
    assign soft_reset_req = soft_s && (state == ST_RUN);

    // rising edge of the sampled time reference counts both units
    always_comb begin
        next_tref_tick  = tref_s && !tref_d;
        next_intc_count = intc_count;
        next_time_base  = time_base;
        // a tied-low input never ticks, counters stay put
        if (tref_tick && !core_reset) begin
            next_intc_count = intc_count + TBASE_W'(1);
            next_time_base  = time_base + TBASE_W'(1);
        end
        if (core_reset) begin
            next_intc_count = '0;
            next_time_base  = '0;
        end
    end

    // tref_d is the sampling latch; edges slower than two clocks are kept
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tref_d     <= 1'b0;
            tref_tick  <= 1'b0;
            intc_count <= '0;
            time_base  <= '0;
        end else begin
            tref_d     <= tref_s;
            tref_tick  <= next_tref_tick;
            intc_count <= next_intc_count;
            time_base  <= next_time_base;
        end
    end
endmodule

// ==== hw/reset_ctrl.sv ====
// board end: drives hard and soft reset, straps and a time reference
`timescale 1ns/10ps
module reset_ctrl #(
    parameter int STRAP_W   = rst_seq_pkg::STRAP_W,
    parameter int HARD_CYC  = rst_seq_pkg::HARD_MIN_CYC,
    parameter int TREF_DIV  = 8
) (
    input  wire logic               clk_sys,
    input  wire logic               rst,
    rst_link_if.ctrl                link,
    input  wire logic [STRAP_W-1:0] strap_val,
    input  wire logic               soft_req,
    input  wire logic               tref_en,
    output logic                    busy
);
    localparam int CW = $clog2(HARD_CYC + rst_seq_pkg::CLK_STABLE_CYC + 2);
    localparam int TW = $clog2(TREF_DIV + 1);

    typedef enum logic [2:0] {
        C_HARD = 3'h1,
        C_HOLD = 3'h2,
        C_IDLE = 3'h4
    } ctrl_state_t;

    ctrl_state_t        state;
    ctrl_state_t        next_state;
    logic [CW-1:0]      cnt;
    logic [CW-1:0]      next_cnt;
    logic [1:0]         soft_cnt;
    logic [1:0]         next_soft_cnt;
    logic [STRAP_W-1:0] next_strap;
    logic               next_oe;
    logic [TW-1:0]      tcnt;
    logic [TW-1:0]      next_tcnt;
    logic               next_tref;

    // hard reset held for the sum of assertion and clock-stable time
    always_comb begin
        next_state    = state;
        next_cnt      = cnt + CW'(1);
        next_strap    = strap_val;
        next_oe       = link.strap_oe;
        next_soft_cnt = (soft_cnt != 2'h0) ? soft_cnt - 2'h1 : 2'h0;
        case (state)
            C_HARD: begin
                next_oe = 1'b1; // straps valid well before release
                if (cnt == CW'(HARD_CYC + rst_seq_pkg::CLK_STABLE_CYC - 1)) begin
                    next_state = C_HOLD;
                    next_cnt   = '0;
                end
            end
            C_HOLD: begin
                // keep straps past hold, drop before release limit
                next_strap = link.strap_out;
                if (cnt == CW'(rst_seq_pkg::STRAP_HOLD_CYC + 1)) begin
                    next_oe    = 1'b0;
                    next_state = C_IDLE;
                end
            end
            C_IDLE: begin
                next_cnt = cnt;
                if (soft_req && soft_cnt == 2'h0) begin
                    next_soft_cnt = 2'(rst_seq_pkg::SOFT_MIN_CYC); // three cycles minimum
                end
            end
            default: begin
                next_state = C_HARD;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state              <= C_HARD;
            cnt                <= '0;
            soft_cnt           <= 2'h0;
            link.strap_out     <= rst_seq_pkg::STRAP_RST;
            link.strap_oe      <= 1'b0;
        end else begin
            state              <= next_state;
            cnt                <= next_cnt;
            soft_cnt           <= next_soft_cnt;
            link.strap_out     <= next_strap;
            link.strap_oe      <= next_oe;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            link.hard_reset_in <= 1'b1;
            link.soft_reset_in <= 1'b0;
        end else begin
            link.hard_reset_in <= (next_state == C_HARD);
            link.soft_reset_in <= (next_soft_cnt != 2'h0);
        end
    end

    // time reference: half period of TREF_DIV clocks, tied low when off
    // a high phase runs to its end when disabled, so no phase is ever cut short
    always_comb begin
        next_tcnt = tcnt + TW'(1);
        next_tref = link.tref;
        if (tcnt == TW'(TREF_DIV - 1)) begin
            next_tcnt = '0;
            next_tref = !link.tref && tref_en;
        end
        if (!tref_en && !link.tref) begin
            next_tcnt = '0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tcnt      <= '0;
            link.tref <= 1'b0;
        end else begin
            tcnt      <= next_tcnt;
            link.tref <= next_tref;
        end
    end

    assign busy = (state != C_IDLE) || (soft_cnt != 2'h0);
endmodule

// ==== verification/reset_link_props.sv ====
// interface-side checks of the reset, strap and time-reference link
`timescale 1ns/10ps
module reset_link_props #(
    parameter int STRAP_W  = 8,
    parameter int MIN_HOLD = rst_seq_pkg::HARD_MIN_CYC
) (
    input wire logic               clk_sys,
    input wire logic               rst,
    input wire logic               hard_reset_in,
    input wire logic               soft_reset_in,
    input wire logic               strap_oe,
    input wire logic               tref,
    input wire logic [STRAP_W-1:0] strap_pin
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic [15:0] hard_cnt;
    logic [15:0] next_hard_cnt;

    // saturating count of cycles spent in hard reset
    always_comb begin
        next_hard_cnt = hard_reset_in ? hard_cnt + 16'h0001 : 16'h0000;
        if (hard_cnt == 16'hFFFF) next_hard_cnt = hard_cnt;
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) hard_cnt <= 16'h0000;
        else hard_cnt <= next_hard_cnt;
    end

    a_hard_hold: assert property ($fell(hard_reset_in) |-> hard_cnt >= MIN_HOLD)
        else $error("hard reset released too early");
    a_soft_width: assert property ($rose(soft_reset_in) |-> soft_reset_in [*3])
        else $error("soft reset pulse too short");
    a_strap_setup: assert property ($fell(hard_reset_in) |->
        $past(strap_oe, 4) && strap_pin == $past(strap_pin, 4))
        else $error("straps not valid before release");
    a_strap_hold: assert property ($fell(hard_reset_in) |=> $stable(strap_pin) [*2])
        else $error("straps changed after release");
    a_strap_driven: assert property ($fell(hard_reset_in) |-> strap_oe [*3])
        else $error("strap driver left too soon");
    a_strap_release: assert property ($fell(hard_reset_in) |-> ##[0:5] !strap_oe)
        else $error("strap driver still on");
    a_tref_phase: assert property ($changed(tref) |=> $stable(tref))
        else $error("time reference phase too short");
endmodule

// ==== verification/reset_strap_and_rtc_sampling_tb.sv ====
// self-checking bench: board end and device end joined by the link
`timescale 1ns/10ps
module reset_strap_and_rtc_sampling_tb;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  strap_val = 8'hA5;
    logic        soft_req = 1'b0;
    logic        tref_en = 1'b0;
    logic        busy, core_reset, soft_reset_req, tref_tick, tref_q = 1'b0;
    logic [7:0]  strap_cfg;
    logic [3:0]  pll_locked;
    logic [31:0] intc_count, time_base;
    int          fail_count = 0, num_checks = 0, cyc = 0, rises = 0, ticks = 0, i, sc;
    logic        seen;

    rst_link_if #(.STRAP_W(8)) link ();
    reset_ctrl #(.HARD_CYC(20), .TREF_DIV(4)) u_reset_ctrl (.clk_sys(clk_sys), .rst(rst),
        .link(link.ctrl), .strap_val(strap_val), .soft_req(soft_req), .tref_en(tref_en),
        .busy(busy));
    reset_dev #(.PLL_LOCK_CYC(10)) u_reset_dev (.clk_sys(clk_sys), .rst(rst), .link(link.dev),
        .core_reset(core_reset), .soft_reset_req(soft_reset_req), .strap_cfg(strap_cfg),
        .pll_locked(pll_locked), .tref_tick(tref_tick), .intc_count(intc_count),
        .time_base(time_base));
    reset_link_props #(.MIN_HOLD(rst_seq_pkg::HARD_MIN_CYC)) u_props (.clk_sys(clk_sys),
        .rst(rst), .hard_reset_in(link.hard_reset_in), .soft_reset_in(link.soft_reset_in),
        .strap_oe(link.strap_oe), .tref(link.tref), .strap_pin(link.strap_pin));

    always #50 clk_sys = ~clk_sys;

    // hang guard and count of time-reference rising edges on the wire
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        tref_q <= link.tref;
        if (link.tref === 1'b1 && tref_q === 1'b0) rises <= rises + 1;
        if (tref_tick === 1'b1) ticks <= ticks + 1;
        if (cyc == 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // main sequence: power-on, lock, time reference, soft reset
    initial begin
        tick(12);
        rst = 1'b0;
        check("core_reset", 32'h1, core_reset);
        check("hard_reset_in", 32'h1, link.hard_reset_in);
        check("busy", 32'h1, busy);
        i = 0;
        while (link.hard_reset_in !== 1'b0 && i < 3000) begin
            tick(1);
            i++;
        end
        check("hard released", 32'h0, link.hard_reset_in);
        check("hard hold", 32'h1, i >= rst_seq_pkg::HARD_MIN_CYC);
        check("clock stable", 32'h1, i >= rst_seq_pkg::CLK_STABLE_CYC);
        // core must stay in reset until every pll reports lock
        i = 0;
        while (core_reset !== 1'b0 && i < 40) begin
            tick(1);
            i++;
            if (pll_locked !== 4'hF) check("held in reset", 32'h1, core_reset);
        end
        check("pll_locked", 32'hF, pll_locked);
        check("lock time", 32'h1, i <= 20);
        check("strap_oe", 32'h0, link.strap_oe);
        check("strap_pin", 32'h0, link.strap_pin);
        strap_val = 8'h3C;
        check("strap_cfg", 32'hA5, strap_cfg);
        // tied-low reference leaves counters still
        tick(30);
        check("intc idle", 32'h0, intc_count);
        check("tbase idle", 32'h0, time_base);
        tref_en = 1'b1;
        tick(100);
        tref_en = 1'b0;
        tick(12);
        check("tref rises", 32'h1, rises > 0);
        check("intc_count", rises, intc_count);
        check("time_base", rises, time_base);
        check("tref_tick", rises, ticks);
        // one-cycle request must give a full soft pulse
        soft_req = 1'b1;
        tick(1);
        soft_req = 1'b0;
        sc = 0;
        seen = 1'b0;
        repeat (10) begin
            if (link.soft_reset_in === 1'b1) sc++;
            if (soft_reset_req === 1'b1) seen = 1'b1;
            tick(1);
        end
        check("soft width", 32'h1, sc >= 3);
        check("soft_reset_req", 32'h1, seen);
        check("busy", 32'h0, busy);
        check("strap kept", 32'hA5, strap_cfg);
        tally_and_finish();
    end
endmodule
